// [hdl/shsc_top.sv]
// SD host present-state, host-control, power and block-gap registers.
// Assumes an APB master on CLK_I, card pins asynchronous to CLK_I,
// and a transfer engine on CLK_I that drives the one-cycle strobes.
//
// Operation
// - Command line level readable in a status bit.
// - Four data line levels readable; lowest line shows card busy.
// - Write-protect pin level shown directly; 1 means writable.
// - Raw presence bit is the inverted detect pin, not debounced.
// - Settled bit reads 0 in reset or debouncing, 1 when stable.
// - Debounced presence bit; rise signals insertion, fall signals removal.
// - Read-available bit follows buffered block data; rise raises read-ready event.
// - Write-space bit follows buffer space; rise raises write-ready event.
// - Read-active sets after read command end or resume.
// - Read-active clears on last block or on a halt at gap.
// - Write-active sets after write command end or resume.
// - Write-active clears after final CRC status or halt at gap.
// - Write-active fall while halt requested raises gap event.
// - Re-tuning bit shows a pending card re-tuning request.
// - Bus-busy bit set while any data line is in use.
// - Data inhibit is busy or read-active; its fall raises done event.
// - Command inhibit sets on command write, clears on response outside an auto sequence or on auto end.
// - Detect source selects test level or physical pin.
// - DMA field: 00 simple DMA, 10 ADMA2, others reserved.
// - Bus width bit selects 4-bit when 1, else 1-bit.
// - Voltage select resets to 6; 7, 6, 5 valid codes.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module shsc_top #(
  parameter int DEBOUNCE_CYC = shsc_pkg::DEBOUNCE_CYC
) (
  input  wire logic                      CLK_I,
  input  wire logic                      RST_B_I,
  input  wire logic                      PSEL_I,
  input  wire logic                      PENABLE_I,
  input  wire logic                      PWRITE_I,
  input  wire logic [shsc_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]               PWDATA_I,
  output logic      [31:0]               PRDATA_O,
  output logic                           PREADY_O,
  output logic                           PSLVERR_O,
  input  wire logic                      LINK_CLK_I,
  input  wire logic                      CMD_LINE_I,
  input  wire logic [3:0]                CARD_BUS_LINES_I,
  input  wire logic                      WRITE_PROTECT_PIN_I,
  input  wire logic                      PRESENCE_PIN_N_I,
  input  wire logic                      BUF_RD_AVAIL_I,
  input  wire logic                      BUF_WR_SPACE_I,
  input  wire logic                      RD_CMD_END_I,
  input  wire logic                      WR_CMD_END_I,
  input  wire logic                      RD_LAST_BLK_I,
  input  wire logic                      RD_BLK_END_I,
  input  wire logic                      WR_LAST_CRC_I,
  input  wire logic                      WR_BLK_CRC_I,
  input  wire logic                      DAT_IN_USE_I,
  input  wire logic                      RETUNE_REQ_I,
  input  wire logic                      RESP_END_I,
  input  wire logic                      AUTO_SEQ_I,
  input  wire logic                      AUTO_DONE_I,
  output logic      [shsc_pkg::EV_W-1:0] EVENT_O,
  output logic      [15:0]               CMD_WORD_O,
  output logic                           CMD_ISSUE_O,
  output logic                           DMA_SIMPLE_O,
  output logic                           DMA_ADMA2_O,
  output logic                           BUS_4BIT_O,
  output logic                           HIGH_SPEED_SELECT_O,
  output logic                           ACTIVITY_LAMP_O,
  output logic      [2:0]                VOLT_SEL_O,
  output logic                           BUS_POWER_O,
  output logic      [3:0]                GAP_CTRL_O
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic       link_d_r;
  logic       link_rise;
  logic       cmd_s2;
  logic [3:0] dat_s2;
  logic       wp_s2;
  logic       cdn_s2;
  logic       link_s2;

  // Reset to the levels the status registers reset to, so no false edge
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_s1_r <= 8'h7d;
      pin_s2_r <= 8'h7d;
      link_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {LINK_CLK_I, CMD_LINE_I, CARD_BUS_LINES_I,
                   WRITE_PROTECT_PIN_I, PRESENCE_PIN_N_I};
      pin_s2_r <= pin_s1_r;
      link_d_r <= link_s2;
    end
  end

  assign link_s2   = pin_s2_r[7];
  assign cmd_s2    = pin_s2_r[6];
  assign dat_s2    = pin_s2_r[5:2];
  assign wp_s2     = pin_s2_r[1];
  assign cdn_s2    = pin_s2_r[0];
  assign link_rise = link_s2 & ~link_d_r;

  // ----------------------------------------------------------------
  // Line levels, CMD and DAT sampled on link clock rising edges, write-protect and raw presence every cycle
  // ----------------------------------------------------------------
  logic       cmd_lvl_r;
  logic [3:0] dat_lvl_r;
  logic       wp_r;
  logic       raw_r;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cmd_lvl_r <= 1'b1;
      dat_lvl_r <= 4'hf;
      wp_r      <= 1'b0;
      raw_r     <= 1'b0;
    end else begin
      if (link_rise) begin
        cmd_lvl_r <= cmd_s2;
        dat_lvl_r <= dat_s2;
      end
      wp_r  <= wp_s2;
      raw_r <= ~cdn_s2;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0]  hostctl_r;
  logic [2:0]  volt_r;
  logic        power_r;
  logic [3:0]  gap_r;
  logic [15:0] cmd_r;
  logic [5:0]  ev_en_r;
  logic        wr_hit;
  logic        hit;
  logic [7:0]  idx;
  logic        wr_cmd;
  logic        rd_resume;
  logic        wr_resume;
  logic        last_wr_r;
  logic        inserted;
  logic        stable;
  logic        read_xfer_r;
  logic        write_xfer_r;

  assign idx    = PADDR_I[9:2];
  assign hit    = (PADDR_I[1:0] == 2'h0) &&
                  (idx == shsc_pkg::IDX_CMD || idx == shsc_pkg::IDX_PRESENT ||
                   idx == shsc_pkg::IDX_HOSTCTL || idx == shsc_pkg::IDX_PWR ||
                   idx == shsc_pkg::IDX_GAP || idx == shsc_pkg::IDX_EVT_EN);
  assign wr_hit = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & hit;
  assign wr_cmd = wr_hit && idx == shsc_pkg::IDX_CMD;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      hostctl_r <= 8'h00;
      volt_r    <= shsc_pkg::VOLT_RST;
      power_r   <= 1'b0;
      cmd_r     <= 16'h0000;
      ev_en_r   <= 6'h00;
    end else begin
      if (wr_hit && idx == shsc_pkg::IDX_HOSTCTL) begin
        hostctl_r <= PWDATA_I[7:0] & 8'hdf;
      end
      if (wr_hit && idx == shsc_pkg::IDX_PWR) begin
        volt_r  <= PWDATA_I[3:1];
        power_r <= PWDATA_I[0];
      end
      if (!inserted) begin
        power_r <= 1'b0;
      end
      if (wr_cmd) begin
        cmd_r <= PWDATA_I[15:0];
      end
      if (wr_hit && idx == shsc_pkg::IDX_EVT_EN) begin
        ev_en_r <= PWDATA_I[5:0];
      end
    end
  end

  // Continue request clears itself when the transfer restarts
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      gap_r <= 4'h0;
    end else if (wr_hit && idx == shsc_pkg::IDX_GAP) begin
      gap_r <= PWDATA_I[3:0];
    end else if (rd_resume || wr_resume) begin
      gap_r[shsc_pkg::GAP_CONT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Card presence
  // ----------------------------------------------------------------
  logic det_src;

  assign det_src = hostctl_r[shsc_pkg::HC_DET_SEL] ?
                   hostctl_r[shsc_pkg::HC_DET_TEST] : ~cdn_s2;

  shsc_debounce #(
    .CYCLES (DEBOUNCE_CYC)
  ) u_debounce (
    .clk_i    (CLK_I),
    .rst_b_i  (RST_B_I),
    .level_i  (det_src),
    .stable_o (stable),
    .level_o  (inserted)
  );

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  logic buf_rd_r;
  logic buf_wr_r;
  logic retune_r;
  logic dat_act_r;
  logic dat_inh_r;
  logic cmd_inh_r;
  logic ins_d_r;
  logic stop;

  assign stop      = gap_r[shsc_pkg::GAP_STOP];
  assign rd_resume = gap_r[shsc_pkg::GAP_CONT] & ~stop & ~last_wr_r & ~read_xfer_r;
  assign wr_resume = gap_r[shsc_pkg::GAP_CONT] & ~stop & last_wr_r & ~write_xfer_r;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      last_wr_r <= 1'b0;
    end else if (WR_CMD_END_I) begin
      last_wr_r <= 1'b1;
    end else if (RD_CMD_END_I) begin
      last_wr_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      read_xfer_r <= 1'b0;
    end else if (RD_CMD_END_I || rd_resume) begin
      read_xfer_r <= 1'b1;
    end else if (RD_LAST_BLK_I || (stop && RD_BLK_END_I)) begin
      read_xfer_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      write_xfer_r <= 1'b0;
    end else if (WR_CMD_END_I || wr_resume) begin
      write_xfer_r <= 1'b1;
    end else if (WR_LAST_CRC_I || (stop && WR_BLK_CRC_I)) begin
      write_xfer_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      buf_rd_r  <= 1'b0;
      buf_wr_r  <= 1'b0;
      retune_r  <= 1'b0;
      dat_act_r <= 1'b0;
      dat_inh_r <= 1'b0;
      ins_d_r   <= 1'b0;
    end else begin
      buf_rd_r  <= BUF_RD_AVAIL_I;
      buf_wr_r  <= BUF_WR_SPACE_I;
      retune_r  <= RETUNE_REQ_I;
      dat_act_r <= DAT_IN_USE_I;
      dat_inh_r <= DAT_IN_USE_I | RD_CMD_END_I | rd_resume |
                   (read_xfer_r & ~(RD_LAST_BLK_I | (stop & RD_BLK_END_I)));
      ins_d_r   <= inserted;
    end
  end

  // Write of the command register wins over a response in the same cycle
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cmd_inh_r <= 1'b0;
    end else if (wr_cmd) begin
      cmd_inh_r <= 1'b1;
    end else if ((RESP_END_I && !AUTO_SEQ_I) || AUTO_DONE_I) begin
      cmd_inh_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Events and decoded control outputs
  // ----------------------------------------------------------------
  logic [5:0] ev_raw;

  always_comb begin
    ev_raw                      = 6'h00;
    ev_raw[shsc_pkg::EV_INSERT] = inserted & ~ins_d_r;
    ev_raw[shsc_pkg::EV_REMOVE] = ~inserted & ins_d_r;
    ev_raw[shsc_pkg::EV_RD_RDY] = BUF_RD_AVAIL_I & ~buf_rd_r;
    ev_raw[shsc_pkg::EV_WR_RDY] = BUF_WR_SPACE_I & ~buf_wr_r;
    ev_raw[shsc_pkg::EV_GAP]    = stop & write_xfer_r &
                                  (WR_LAST_CRC_I | WR_BLK_CRC_I) &
                                  ~(WR_CMD_END_I | wr_resume);
    ev_raw[shsc_pkg::EV_DONE]   = dat_inh_r & ~DAT_IN_USE_I & ~rd_resume &
                                  ~RD_CMD_END_I &
                                  ~(read_xfer_r & ~(RD_LAST_BLK_I |
                                    (stop & RD_BLK_END_I)));
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      EVENT_O      <= 6'h00;
      CMD_ISSUE_O  <= 1'b0;
      DMA_SIMPLE_O <= 1'b1;
      DMA_ADMA2_O  <= 1'b0;
    end else begin
      EVENT_O      <= ev_raw & ev_en_r;
      CMD_ISSUE_O  <= wr_cmd;
      DMA_SIMPLE_O <= hostctl_r[4:3] == shsc_pkg::DMA_SDMA;
      DMA_ADMA2_O  <= hostctl_r[4:3] == shsc_pkg::DMA_ADMA2;
    end
  end

  assign CMD_WORD_O          = cmd_r;
  assign BUS_4BIT_O          = hostctl_r[shsc_pkg::HC_WIDTH];
  assign HIGH_SPEED_SELECT_O = hostctl_r[shsc_pkg::HC_HS];
  assign ACTIVITY_LAMP_O     = hostctl_r[shsc_pkg::HC_LAMP];
  assign VOLT_SEL_O          = volt_r;
  assign BUS_POWER_O         = power_r;
  assign GAP_CTRL_O          = gap_r;

  // ----------------------------------------------------------------
  // APB read path, one-cycle access phase
  // ----------------------------------------------------------------
  logic [31:0] present;
  logic [31:0] rdata;

  always_comb begin
    present                        = 32'h0000_0000;
    present[shsc_pkg::PS_CMD_LVL]  = cmd_lvl_r;
    present[23:20]                 = dat_lvl_r;
    present[shsc_pkg::PS_WP]       = wp_r;
    present[shsc_pkg::PS_RAW]      = raw_r;
    present[shsc_pkg::PS_STABLE]   = stable;
    present[shsc_pkg::PS_INSERTED] = inserted;
    present[shsc_pkg::PS_BUF_RD]   = buf_rd_r;
    present[shsc_pkg::PS_BUF_WR]   = buf_wr_r;
    present[shsc_pkg::PS_RD_XFER]  = read_xfer_r;
    present[shsc_pkg::PS_WR_XFER]  = write_xfer_r;
    present[shsc_pkg::PS_RETUNE]   = retune_r;
    present[shsc_pkg::PS_DAT_ACT]  = dat_act_r;
    present[shsc_pkg::PS_DAT_INH]  = dat_inh_r;
    present[shsc_pkg::PS_CMD_INH]  = cmd_inh_r;
  end

  always_comb begin
    if (idx == shsc_pkg::IDX_PRESENT) begin
      rdata = present;
    end else if (idx == shsc_pkg::IDX_HOSTCTL) begin
      rdata = {24'h000000, hostctl_r};
    end else if (idx == shsc_pkg::IDX_PWR) begin
      rdata = {28'h0000000, volt_r, power_r};
    end else if (idx == shsc_pkg::IDX_GAP) begin
      rdata = {28'h0000000, gap_r};
    end else if (idx == shsc_pkg::IDX_CMD) begin
      rdata = {16'h0000, cmd_r};
    end else if (idx == shsc_pkg::IDX_EVT_EN) begin
      rdata = {26'h0, ev_en_r};
    end else begin
      rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else if (PSEL_I && !PENABLE_I) begin
      PRDATA_O  <= (hit && !PWRITE_I) ? rdata : 32'h0000_0000;
      PREADY_O  <= 1'b1;
      PSLVERR_O <= ~hit;
    end else begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_cmd_write;
    wr_cmd ##1 CMD_ISSUE_O;
  endsequence

  sequence s_last_crc;
    write_xfer_r && WR_LAST_CRC_I && !WR_CMD_END_I && !wr_resume;
  endsequence

  a_cmd_level: assert property (link_rise |=> cmd_lvl_r == $past(cmd_s2))
    else $error("cmd level not sampled");
  a_dat_level: assert property (link_rise |=> dat_lvl_r == $past(dat_s2))
    else $error("data levels not sampled");
  a_wp_level: assert property (##1 wp_r == $past(wp_s2))
    else $error("write protect level wrong");
  a_raw_detect: assert property (##1 raw_r != $past(cdn_s2))
    else $error("raw presence not inverted pin");
  a_insert_event: assert property ($rose(inserted) && ev_en_r[0] |=> EVENT_O[0])
    else $error("insertion event missing");
  a_read_set: assert property (RD_CMD_END_I |=> read_xfer_r ##0 dat_inh_r)
    else $error("read active not set");
  a_write_clear: assert property (s_last_crc |=> !write_xfer_r)
    else $error("write active not cleared");
  a_gap_event: assert property (
      s_last_crc and (stop && ev_en_r[4]) |=> EVENT_O[4] ##1 !EVENT_O[4])
    else $error("gap event wrong");
  a_cmd_inhibit: assert property (s_cmd_write |-> cmd_inh_r)
    else $error("command inhibit not set");
  a_power_clear: assert property (!inserted |=> !power_r)
    else $error("bus power kept without card");

endmodule : shsc_top

// [hdl/shsc_pkg.sv]
// Constants of the SD host state and control block: register indices,
// field positions, reset values, encodings and timing counts.
// Assumes a 25 MHz system clock and a 32-bit APB register port.
package shsc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 10;
  localparam logic [7:0] IDX_CMD     = 8'h0e;
  localparam logic [7:0] IDX_PRESENT = 8'h24;
  localparam logic [7:0] IDX_HOSTCTL = 8'h28;
  localparam logic [7:0] IDX_PWR     = 8'h29;
  localparam logic [7:0] IDX_GAP     = 8'h2a;
  localparam logic [7:0] IDX_EVT_EN  = 8'h30;

  // ----------------------------------------------------------------
  // Present state fields
  // ----------------------------------------------------------------
  localparam int PS_CMD_LVL  = 24;
  localparam int PS_DAT_LO   = 20;
  localparam int PS_WP       = 19;
  localparam int PS_RAW      = 18;
  localparam int PS_STABLE   = 17;
  localparam int PS_INSERTED = 16;
  localparam int PS_BUF_RD   = 11;
  localparam int PS_BUF_WR   = 10;
  localparam int PS_RD_XFER  = 9;
  localparam int PS_WR_XFER  = 8;
  localparam int PS_RETUNE   = 3;
  localparam int PS_DAT_ACT  = 2;
  localparam int PS_DAT_INH  = 1;
  localparam int PS_CMD_INH  = 0;

  // ----------------------------------------------------------------
  // Control fields and encodings
  // ----------------------------------------------------------------
  localparam int HC_DET_SEL  = 7;
  localparam int HC_DET_TEST = 6;
  localparam int HC_DMA_LO   = 3;
  localparam int HC_HS       = 2;
  localparam int HC_WIDTH    = 1;
  localparam int HC_LAMP     = 0;
  localparam int PWR_VOLT_LO = 1;
  localparam int PWR_ON      = 0;
  localparam int GAP_CONT    = 1;
  localparam int GAP_STOP    = 0;

  localparam logic [1:0] DMA_SDMA  = 2'h0;
  localparam logic [1:0] DMA_ADMA2 = 2'h2;
  localparam logic [2:0] VOLT_33   = 3'h7;
  localparam logic [2:0] VOLT_30   = 3'h6;
  localparam logic [2:0] VOLT_18   = 3'h5;
  localparam logic [2:0] VOLT_RST  = VOLT_30;

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------
  localparam int EV_W      = 6;
  localparam int EV_INSERT = 0;
  localparam int EV_REMOVE = 1;
  localparam int EV_RD_RDY = 2;
  localparam int EV_WR_RDY = 3;
  localparam int EV_GAP    = 4;
  localparam int EV_DONE   = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEBOUNCE_US   = 1000;
  localparam int DEBOUNCE_CYC  = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;

endpackage : shsc_pkg

// [hdl/shsc_debounce.sv]
// Debouncer for the card presence level.
// Assumes its input is already in the CLK_I domain.
`timescale 1ns/1ps
module shsc_debounce #(
  parameter int CYCLES = 25000
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic level_i,
  output logic      stable_o,
  output logic      level_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic          last_r;
  logic [CW-1:0] cnt_r;

  // ----------------------------------------------------------------
  // Restart the count on every change, settle when it expires
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_r   <= 1'b0;
      cnt_r    <= '0;
      stable_o <= 1'b0;
      level_o  <= 1'b0;
    end else begin
      last_r <= level_i;
      if (level_i != last_r) begin
        cnt_r    <= '0;
        stable_o <= 1'b0;
      end else if (cnt_r == LAST) begin
        stable_o <= 1'b1;
        level_o  <= last_r;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

endmodule : shsc_debounce

// [tb/shsc_card_model.sv]
// Card side of the SD bus: link clock and CMD/DAT line levels.
// Assumes the bench raises frame_i while the card is clocked.
`timescale 1ns/1ps
module shsc_card_model (
  input  wire logic       frame_i,
  input  wire logic       cmd_i,
  input  wire logic [3:0] dat_i,
  output logic            link_clk_o,
  output logic            cmd_o,
  output logic      [3:0] dat_o
);
  // ---
  // Link clock, still between frames
  // ---
  initial link_clk_o = 1'b0;
  always begin
    #160;
    link_clk_o = frame_i ? ~link_clk_o : 1'b0;
  end
  // Released lines sit at their pull-up level
  assign cmd_o = frame_i ? cmd_i : 1'b1;
  assign dat_o = frame_i ? dat_i : 4'hf;
endmodule : shsc_card_model

// [tb/shsc_top_bench.sv]
// Bench of the SD host state block: APB master, engine strobes, pins.
// Assumes shsc_pkg and the design are compiled first.
`timescale 1ns/1ps
module shsc_top_bench;
  localparam int DB = 8;
  logic        clk, rst_b, psel, pen, pwr, e, lclk, cmd;
  logic        frame, cmd_v, wp_v, pres, dsim, dadm, b4, bpow, hs, lamp;
  logic [15:0] cw;
  logic [9:0]  padr;
  logic [31:0] pwd, prd, q, seed;
  logic        rdy, err;
  logic [3:0]  dat, dat_v, gctl;
  logic [7:0]  stb;
  logic [4:0]  lv;
  logic [5:0]  ev;
  logic [2:0]  vsel;
  int          mismatches, num_checks, evc[6], ev0[6];

  always #20 clk = ~clk;

  shsc_top #(.DEBOUNCE_CYC(DB)) shsc_top_i (
    .CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
    .LINK_CLK_I(lclk), .CMD_LINE_I(cmd), .CARD_BUS_LINES_I(dat),
    .WRITE_PROTECT_PIN_I(wp_v), .PRESENCE_PIN_N_I(~pres), .BUF_RD_AVAIL_I(lv[0]),
    .BUF_WR_SPACE_I(lv[1]), .RD_CMD_END_I(stb[0]), .WR_CMD_END_I(stb[1]),
    .RD_LAST_BLK_I(stb[2]), .RD_BLK_END_I(stb[3]), .WR_LAST_CRC_I(stb[4]),
    .WR_BLK_CRC_I(stb[5]), .DAT_IN_USE_I(lv[2]), .RETUNE_REQ_I(lv[3]),
    .RESP_END_I(stb[6]), .AUTO_SEQ_I(lv[4]), .AUTO_DONE_I(stb[7]), .EVENT_O(ev),
    .CMD_WORD_O(cw), .CMD_ISSUE_O(), .DMA_SIMPLE_O(dsim), .DMA_ADMA2_O(dadm),
    .BUS_4BIT_O(b4), .HIGH_SPEED_SELECT_O(hs), .ACTIVITY_LAMP_O(lamp),
    .VOLT_SEL_O(vsel), .BUS_POWER_O(bpow), .GAP_CTRL_O(gctl));

  shsc_card_model shsc_card_model_i (
    .frame_i(frame), .cmd_i(cmd_v), .dat_i(dat_v),
    .link_clk_o(lclk), .cmd_o(cmd), .dat_o(dat));

  // Event pulses are counted, so a missed or doubled pulse shows
  always @(posedge clk) begin
    for (int k = 0; k < 6; k++) if (ev[k] === 1'b1) evc[k] <= evc[k] + 1;
  end

  // ---
  // Helpers
  // ---
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    {psel, pen, pwr, padr, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      mismatches++;
      final_report();
    end
    q = prd;
    e = err;
    {psel, pen} <= 2'b00;
    @(posedge clk);
  endtask : apb

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic pulse(input int b);
    stb[b] <= 1'b1;
    @(posedge clk);
    stb[b] <= 1'b0;
    @(posedge clk);
  endtask : pulse

  task automatic rdk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask : rdk

  task automatic pst(input logic [31:0] m, input logic [31:0] x);
    rdk(10'h090, m, x);
  endtask : pst

  task automatic snap();
    foreach (evc[k]) ev0[k] = evc[k];
  endtask : snap

  task automatic evchk(input int k, input int x);
    chk(32'(evc[k] - ev0[k]), 32'(x));
  endtask : evchk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] pins(logic c, logic [3:0] d, logic w, logic p);
    return {7'h0, c, d, w, p, 18'h0};
  endfunction : pins

  // ---
  // Main sequence
  // ---
  initial begin
    {clk, rst_b, psel, pen, pwr, frame, cmd_v, wp_v, pres, padr, pwd, dat_v, stb, lv} = '0;
    foreach (evc[k]) evc[k] = 0;
    seed = 32'hcc87dc8a;
    tick(4);
    rst_b <= 1'b1;
    apb(1'b0, 10'h0a4, 32'h0);
    chk(q, 32'h0000000c);
    apb(1'b1, 10'h0c0, 32'h3f);
    frame <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      {pres, wp_v, dat_v, cmd_v} <= seed[6:0];
      tick(12);
      pst(32'h01fc0000, pins(seed[0], seed[4:1], seed[5], seed[6]));
    end
    frame <= 1'b0;
    pres <= 1'b0;
    tick(30);
    $display("pin levels done");
    apb(1'b1, 10'h0a4, 32'h0f);
    rdk(10'h0a4, 32'h0f, 32'h0e);
    snap();
    pres <= 1'b1;
    tick(4);
    pst(32'h00070000, 32'h00040000);
    tick(30);
    pst(32'h00070000, 32'h00070000);
    evchk(0, 1);
    for (int v = 5; v < 8; v++) begin
      apb(1'b1, 10'h0a4, 32'(v * 2));
      apb(1'b1, 10'h0a4, 32'(v * 2 + 1));
      rdk(10'h0a4, 32'hff, 32'(v * 2 + 1));
      chk({vsel, bpow}, 32'(v * 2 + 1));
    end
    pres <= 1'b0;
    tick(30);
    evchk(1, 1);
    chk(bpow, 32'h0);
    snap();
    apb(1'b1, 10'h0a0, 32'hc0);
    tick(30);
    pst(32'h00070000, 32'h00030000);
    evchk(0, 1);
    $display("card detect done");
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      apb(1'b1, 10'h0a0, {27'h0, c[1:0], seed[2], seed[0], seed[1]});
      rdk(10'h0a0, 32'hff, {27'h0, c[1:0], seed[2], seed[0], seed[1]});
      chk({dsim, dadm, b4, hs, lamp}, {c == 0, c == 2, seed[0], seed[2:1]});
    end
    snap();
    pulse(0);
    pst(32'h0302, 32'h0202);
    pulse(2);
    pst(32'h0302, 32'h0);
    evchk(5, 1);
    apb(1'b1, 10'h0a8, 32'h1);
    chk(gctl, 32'h1);
    pulse(0);
    pulse(3);
    pst(32'h0200, 32'h0);
    pulse(1);
    pulse(5);
    pst(32'h0100, 32'h0);
    evchk(4, 1);
    apb(1'b1, 10'h0a8, 32'h2);
    pst(32'h0100, 32'h0100);
    pulse(4);
    pst(32'h0100, 32'h0);
    evchk(4, 1);
    apb(1'b1, 10'h0a8, 32'h1);
    pulse(1);
    pulse(4);
    pst(32'h0100, 32'h0);
    evchk(4, 2);
    $display("transfers done");
    apb(1'b1, 10'h038, 32'h1a);
    chk(cw, 32'h1a);
    pst(32'h1, 32'h1);
    pulse(6);
    pst(32'h1, 32'h0);
    lv[4] <= 1'b1;
    apb(1'b1, 10'h038, 32'h1a);
    pulse(6);
    pst(32'h1, 32'h1);
    pulse(7);
    pst(32'h1, 32'h0);
    snap();
    lv <= 5'h0f;
    tick(3);
    pst(32'h0c0e, 32'h0c0e);
    evchk(2, 1);
    evchk(3, 1);
    lv <= 5'h00;
    tick(3);
    pst(32'h0c0e, 32'h0);
    evchk(5, 1);
    apb(1'b0, 10'h3fc, 32'h0);
    chk(q, 32'h0);
    chk(e, 32'h1);
    $display("status and map done");
    final_report();
  end
endmodule : shsc_top_bench
